// file: rtl/sef_dev.sv
// EEPROM serial front end, array and self-timed write cycle
`timescale 1ns/1ps
`include "sef_defines.svh"

// Notes on behaviour
// - Mode 0 only, clock idles low.
// - Byte-wide array of 32768 locations.
// - Pages of 128 bytes, byte or page write.
// - Partial page writes only sent bytes.
// - Self-timed programming, done within 5 ms.
// - Pause input suspends, transfer resumes in place.
// - Reset ignores input, returns to standby.
// - All bytes shifted MSB first.
// - First byte is op-code, only valid decoded.
// - Master sends any op-code given, unchecked.
// - Master starts instruction with select falling.
// - Device active only while select is low.
// - Select rising ends op or starts programming.
// - Standby when deselected, output released.
// - Input sampled on shift clock rising edge.
// - Output updated on shift clock falling edge.
// - Master generates shift clock, device receives.
// - Pause changes only while shift clock low.
// - While programming only status read accepted.
module sef_dev #(
    parameter int DEPTH   = `SEF_MEM_DEPTH,
    parameter int PAGE    = `SEF_PAGE_BYTES,
    parameter int TWC_CYC = `SEF_TWC_CYC
) (
    input  wire logic CLK,
    input  wire logic ARST_N,
    sef_if.dev        LINK,
    output logic      BUSY
);
    import sef_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(PAGE);
    localparam int TW = $clog2(TWC_CYC + 1);

    function automatic logic [7:0] status_byte(input logic busy);
        status_byte = 8'h00;
        status_byte[`SEF_ST_BUSY_BIT] = busy;
    endfunction : status_byte

    logic [7:0]       mem      [DEPTH];
    logic [7:0]       pbuf_q   [PAGE];
    logic [PAGE-1:0]  pval_q;
    logic [2:0]       bit_q;
    logic [6:0]       sh_q;
    sef_phase_t       ph_q;
    logic             ab_q;
    logic             is_wr_q;
    logic [15:0]      addr_q;
    logic [7:0]       tx_q;
    logic             so_q;
    logic             oe_q;
    logic             tog_q;
    logic             bs1_q;
    logic             bs2_q;
    logic             cs1_q;
    logic             cs2_q;
    logic             t1_q;
    logic             t2_q;
    logic             t3_q;
    logic             armed_q;
    logic             busy_q;
    logic [TW-1:0]    cnt_q;

    logic             frame_rst;
    logic [7:0]       rx;
    logic             byte_end;
    logic [15:0]      addr_new;
    logic [AW-1:0]    rd_next;
    logic             commit;

    // Deselect or reset puts the frame logic in standby
    assign frame_rst = ~ARST_N | LINK.cs_n;
    assign rx        = {sh_q, LINK.si};
    assign byte_end  = (bit_q == 3'h7);
    assign addr_new  = {addr_q[7:0], rx};
    assign rd_next   = addr_q[AW-1:0] + AW'(1);

    // Busy level into the shift clock domain
    always_ff @(posedge LINK.sck or negedge ARST_N) begin
        if (!ARST_N) begin
            bs1_q <= 1'b0;
            bs2_q <= 1'b0;
        end else begin
            bs1_q <= busy_q;
            bs2_q <= bs1_q;
        end
    end

    // Bit counting and instruction phase
    always_ff @(posedge LINK.sck or posedge frame_rst) begin
        if (frame_rst) begin
            bit_q   <= 3'h0;
            sh_q    <= 7'h00;
            ph_q    <= PH_OPC;
            ab_q    <= 1'b0;
            is_wr_q <= 1'b0;
        end else if (LINK.hold_n) begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= rx[6:0];
            if (byte_end) begin
                case (ph_q)
                    PH_OPC: begin
                        is_wr_q <= (rx == `SEF_OP_WRITE);
                        if (rx == `SEF_OP_RDSTAT) begin
                            ph_q <= PH_STAT;
                        end else if (bs2_q) begin
                            ph_q <= PH_IGN;
                        end else if (rx == `SEF_OP_READ || rx == `SEF_OP_WRITE) begin
                            ph_q <= PH_ADDR;
                        end else begin
                            ph_q <= PH_IGN;
                        end
                    end
                    PH_ADDR: begin
                        ab_q <= 1'b1;
                        if (ab_q) begin
                            ph_q <= is_wr_q ? PH_WDATA : PH_RDATA;
                        end
                    end
                    default: ph_q <= ph_q;
                endcase
            end
        end
    end

    // Address register: loads, then advances per data byte
    always_ff @(posedge LINK.sck or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_q <= 16'h0000;
        end else if (!LINK.cs_n && LINK.hold_n && byte_end) begin
            case (ph_q)
                PH_ADDR:  addr_q <= addr_new;
                PH_WDATA: addr_q <= {addr_q[15:PW], addr_q[PW-1:0] + PW'(1)};
                PH_RDATA: addr_q <= {{(16 - AW){1'b0}}, rd_next};
                default:  addr_q <= addr_q;
            endcase
        end
    end

    // Page buffer, byte valid marks and commit toggle
    always_ff @(posedge LINK.sck or negedge ARST_N) begin
        if (!ARST_N) begin
            pval_q <= '0;
            tog_q  <= 1'b0;
        end else if (!LINK.cs_n && LINK.hold_n && byte_end) begin
            if (ph_q == PH_OPC && rx == `SEF_OP_WRITE && !bs2_q) begin
                pval_q <= '0;
            end else if (ph_q == PH_WDATA) begin
                pbuf_q[addr_q[PW-1:0]] <= rx;
                pval_q[addr_q[PW-1:0]] <= 1'b1;
                if (pval_q == '0) begin
                    tog_q <= ~tog_q;
                end
            end
        end
    end

    // Byte to be shifted out next
    always_ff @(posedge LINK.sck or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_q <= 8'h00;
        end else if (!LINK.cs_n && LINK.hold_n && byte_end) begin
            if ((ph_q == PH_OPC && rx == `SEF_OP_RDSTAT) || ph_q == PH_STAT) begin
                tx_q <= status_byte(bs2_q);
            end else if (ph_q == PH_ADDR && ab_q) begin
                tx_q <= mem[addr_new[AW-1:0]];
            end else if (ph_q == PH_RDATA) begin
                tx_q <= mem[rd_next];
            end
        end
    end

    // Output bit changes on the falling edge
    always_ff @(negedge LINK.sck or negedge ARST_N) begin
        if (!ARST_N) begin
            so_q <= 1'b0;
        end else if (LINK.hold_n) begin
            so_q <= tx_q[~bit_q];
        end
    end

    always_ff @(negedge LINK.sck or posedge frame_rst) begin
        if (frame_rst) begin
            oe_q <= 1'b0;
        end else if (LINK.hold_n) begin
            oe_q <= (ph_q == PH_RDATA) || (ph_q == PH_STAT);
        end
    end

    assign LINK.so    = so_q;
    assign LINK.so_oe = oe_q & LINK.hold_n;

    // Select and commit toggle into the system clock domain
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cs1_q <= 1'b1;
            cs2_q <= 1'b1;
            t1_q  <= 1'b0;
            t2_q  <= 1'b0;
            t3_q  <= 1'b0;
        end else begin
            cs1_q <= LINK.cs_n;
            cs2_q <= cs1_q;
            t1_q  <= tog_q;
            t2_q  <= t1_q;
            t3_q  <= t2_q;
        end
    end

    // Programming starts once select is back high
    assign commit = armed_q & cs2_q & ~busy_q;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= (armed_q & ~commit) | (t2_q ^ t3_q);
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end else if (commit) begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
        end else if (busy_q) begin
            if (cnt_q == TW'(TWC_CYC - 1)) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + TW'(1);
            end
        end
    end

    assign BUSY = busy_q;

    // Only the bytes sent in the frame are programmed
    always_ff @(posedge CLK) begin
        for (int i = 0; i < PAGE; i++) begin
            if (commit && pval_q[i]) begin
                mem[{addr_q[AW-1:PW], PW'(i)}] <= pbuf_q[i];
            end
        end
    end

endmodule : sef_dev

// file: rtl/sef_defines.svh
// Shared constants for the serial EEPROM front end and its master
`ifndef SEF_DEFINES_SVH
`define SEF_DEFINES_SVH

`define SEF_OP_WRITE      8'h02
`define SEF_OP_READ       8'h03
`define SEF_OP_RDSTAT     8'h05
`define SEF_ST_BUSY_BIT   0
`define SEF_MEM_DEPTH     32768
`define SEF_PAGE_BYTES    128
`define SEF_ADDR_BYTES    2
`define SEF_CLK_MHZ       200
`define SEF_TWC_MAX_NS    5000000
`define SEF_TWC_CYC       ((`SEF_TWC_MAX_NS * `SEF_CLK_MHZ) / 1000)
`define SEF_SCK_HALF      5

`endif

// file: rtl/sef_pkg.sv
// Types for the serial EEPROM front end and its master
package sef_pkg;

    typedef enum logic [2:0] {
        PH_OPC   = 3'b000,
        PH_ADDR  = 3'b001,
        PH_WDATA = 3'b010,
        PH_RDATA = 3'b011,
        PH_STAT  = 3'b100,
        PH_IGN   = 3'b101
    } sef_phase_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_XFER = 2'b01,
        HS_TAIL = 2'b10,
        HS_GAP  = 2'b11
    } sef_hstate_t;

endpackage : sef_pkg

// file: rtl/sef_if.sv
// Serial link between the master and the EEPROM front end
`timescale 1ns/1ps
interface sef_if;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic so;
    logic so_oe;
    logic so_line;

    // Released output line reads high
    assign so_line = so_oe ? so : 1'b1;

    modport dev (
        input  sck,
        input  cs_n,
        input  si,
        input  hold_n,
        output so,
        output so_oe
    );

    modport mst (
        output sck,
        output cs_n,
        output si,
        output hold_n,
        input  so_line
    );
endinterface : sef_if

// file: rtl/sef_host.sv
// SPI master end: drives select, shift clock, pause and data
`timescale 1ns/1ps
`include "sef_defines.svh"

module sef_host #(
    parameter int HALF = `SEF_SCK_HALF
) (
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic       START,
    input  wire logic [7:0] OPCODE,
    input  wire logic [15:0] ADDR,
    input  wire logic       ADDR_EN,
    input  wire logic [7:0] NBYTES,
    input  wire logic [7:0] WDATA,
    input  wire logic       PAUSE,
    output logic            WTAKE,
    output logic [7:0]      RDATA,
    output logic            RVALID,
    output logic            DONE,
    output logic            ACTIVE,
    sef_if.mst              LINK
);
    import sef_pkg::*;

    localparam int DW = $clog2(HALF + 1);

    sef_hstate_t  st_q;
    logic [DW-1:0] div_q;
    logic         sck_q;
    logic         cs_n_q;
    logic         mosi_q;
    logic         hold_n_q;
    logic [7:0]   txb_q;
    logic [7:0]   rxb_q;
    logic [2:0]   bit_q;
    logic [8:0]   idx_q;
    logic [8:0]   last_q;
    logic [8:0]   hdr_q;
    logic [15:0]  addr_q;
    logic         so1_q;
    logic         so2_q;
    logic         wtake_q;
    logic [7:0]   rdata_q;
    logic         rvalid_q;
    logic         done_q;
    logic         tick;
    logic [7:0]   nxt;

    assign tick = (div_q == DW'(HALF - 1));

    always_comb begin
        if (idx_q + 9'd1 < hdr_q) begin
            nxt = (idx_q == 9'd0) ? addr_q[15:8] : addr_q[7:0];
        end else begin
            nxt = WDATA;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            so1_q <= 1'b1;
            so2_q <= 1'b1;
        end else begin
            so1_q <= LINK.so_line;
            so2_q <= so1_q;
        end
    end

    // Pause changes only while the clock is low
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hold_n_q <= 1'b1;
        end else if (!sck_q && !(st_q == HS_XFER && hold_n_q && tick)) begin
            hold_n_q <= ~PAUSE;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q     <= HS_IDLE;
            div_q    <= '0;
            sck_q    <= 1'b0;
            cs_n_q   <= 1'b1;
            mosi_q   <= 1'b0;
            txb_q    <= 8'h00;
            rxb_q    <= 8'h00;
            bit_q    <= 3'h0;
            idx_q    <= 9'h000;
            last_q   <= 9'h000;
            hdr_q    <= 9'h001;
            addr_q   <= 16'h0000;
            wtake_q  <= 1'b0;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            wtake_q  <= 1'b0;
            rvalid_q <= 1'b0;
            done_q   <= 1'b0;
            case (st_q)
                HS_IDLE: begin
                    div_q <= '0;
                    if (START) begin
                        cs_n_q <= 1'b0;
                        mosi_q <= OPCODE[7];
                        txb_q  <= {OPCODE[6:0], 1'b0};
                        addr_q <= ADDR;
                        hdr_q  <= ADDR_EN ? 9'd3 : 9'd1;
                        last_q <= (ADDR_EN ? 9'd2 : 9'd0) + {1'b0, NBYTES};
                        idx_q  <= 9'h000;
                        bit_q  <= 3'h0;
                        st_q   <= HS_XFER;
                    end
                end
                HS_XFER: begin
                    if (hold_n_q) begin
                        div_q <= tick ? '0 : div_q + DW'(1);
                        if (tick && !sck_q) begin
                            sck_q <= 1'b1;
                            rxb_q <= {rxb_q[6:0], so2_q};
                        end else if (tick) begin
                            sck_q <= 1'b0;
                            bit_q <= bit_q + 3'h1;
                            if (bit_q != 3'h7) begin
                                mosi_q <= txb_q[7];
                                txb_q  <= {txb_q[6:0], 1'b0};
                            end else begin
                                if (idx_q >= hdr_q) begin
                                    rdata_q  <= rxb_q;
                                    rvalid_q <= 1'b1;
                                end
                                if (idx_q == last_q) begin
                                    st_q <= HS_TAIL;
                                end else begin
                                    idx_q   <= idx_q + 9'd1;
                                    mosi_q  <= nxt[7];
                                    txb_q   <= {nxt[6:0], 1'b0};
                                    wtake_q <= (idx_q + 9'd1 >= hdr_q);
                                end
                            end
                        end
                    end else begin
                        // Full half period after resume so the returning line settles
                        div_q <= '0;
                    end
                end
                HS_TAIL: begin
                    div_q <= tick ? '0 : div_q + DW'(1);
                    if (tick) begin
                        cs_n_q <= 1'b1;
                        done_q <= 1'b1;
                        st_q   <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    div_q <= tick ? '0 : div_q + DW'(1);
                    if (tick) begin
                        st_q <= HS_IDLE;
                    end
                end
                default: st_q <= HS_IDLE;
            endcase
        end
    end

    assign LINK.sck    = sck_q;
    assign LINK.cs_n   = cs_n_q;
    assign LINK.si     = mosi_q;
    assign LINK.hold_n = hold_n_q;
    assign WTAKE       = wtake_q;
    assign RDATA       = rdata_q;
    assign RVALID      = rvalid_q;
    assign DONE        = done_q;
    assign ACTIVE      = ~cs_n_q;

endmodule : sef_host

// file: dv/sef_props.sv
// Concurrent checks on the serial link between master and front end
`timescale 1ns/1ps
module sef_props #(
    parameter int TWC_CYC = 2000
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic so_line,
    input wire logic BUSY
);
    logic [31:0] busy_cnt_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    // Length of the current programming run
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= BUSY ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end

    AST_MODE0_IDLE: assert property (cs_n |-> !sck)
        else $error("shift clock high while deselected");
    AST_SEL_FALL_LOW: assert property ($fell(cs_n) |-> !sck && !$past(sck))
        else $error("select fell with shift clock high");
    AST_SO_OFF_DESEL: assert property (cs_n |-> !so_oe)
        else $error("output driven while deselected");
    AST_SO_OFF_PAUSE: assert property (!hold_n |-> !so_oe && so_line)
        else $error("output driven while paused");
    AST_SO_FALL_EDGE: assert property (so_oe && $changed(so) |-> $fell(sck))
        else $error("output bit changed off the falling edge");
    AST_OE_FALL_EDGE: assert property ($rose(so_oe) && $past(hold_n) |-> $fell(sck))
        else $error("output enabled off the falling edge");
    AST_SI_LOW_CHANGE: assert property ($changed(si) |-> !sck)
        else $error("input bit changed while shift clock high");
    AST_HOLD_LOW_CHANGE: assert property ($changed(hold_n) |-> !sck && !$past(sck))
        else $error("pause changed while shift clock high");
    AST_BUSY_DESEL: assert property ($rose(BUSY) |-> cs_n && $past(cs_n))
        else $error("programming started while selected");
    AST_BUSY_LEN: assert property ($fell(BUSY) |-> busy_cnt_q == 32'(TWC_CYC))
        else $error("programming run of wrong length");
endmodule : sef_props

// file: dv/tb_spi_eeprom_serial_front_end.sv
// Bench joining master and front end across the serial link
`timescale 1ns/1ps
`include "sef_defines.svh"
module tb_spi_eeprom_serial_front_end;
    localparam int TWC  = 2000;
    localparam int HALF = 5;
    typedef struct {logic [15:0] a; logic [7:0] n; logic [7:0] base; logic [7:0] x;} sef_row_t;

    logic        clk = 1'b0;
    logic        arst_n, start, addr_en, pause, wtake, rvalid, done, active, busy;
    logic [7:0]  opcode, nbytes, wdata, rdata, sh, first_b;
    logic [15:0] addr;
    logic [7:0]  rx [0:255];
    logic [7:0]  mem [0:1023];
    logic        known [0:1023];
    int          error_cnt = 0;
    int          n_compared = 0;
    int          nrx, hi, nb;
    int          pause_at = 100000;
    sef_row_t    rows [3] = '{'{16'h0010, 8'd1, 8'ha5, 8'ha5},
                              '{16'h0080, 8'd128, 8'h00, 8'h00},
                              '{16'h017e, 8'd3, 8'h40, 8'h40}};

    always #2.5 clk = ~clk;

    sef_if sef_if_inst ();
    sef_host #(.HALF(HALF)) sef_host_inst (.CLK(clk), .ARST_N(arst_n), .START(start),
        .OPCODE(opcode), .ADDR(addr), .ADDR_EN(addr_en), .NBYTES(nbytes), .WDATA(wdata),
        .PAUSE(pause), .WTAKE(wtake), .RDATA(rdata), .RVALID(rvalid), .DONE(done),
        .ACTIVE(active), .LINK(sef_if_inst));
    sef_dev #(.DEPTH(1024), .PAGE(128), .TWC_CYC(TWC)) sef_dev_inst (.CLK(clk),
        .ARST_N(arst_n), .LINK(sef_if_inst), .BUSY(busy));
    sef_props #(.TWC_CYC(TWC)) sef_props_inst (.CLK(clk), .ARST_N(arst_n),
        .sck(sef_if_inst.sck), .cs_n(sef_if_inst.cs_n), .si(sef_if_inst.si),
        .hold_n(sef_if_inst.hold_n), .so(sef_if_inst.so), .so_oe(sef_if_inst.so_oe),
        .so_line(sef_if_inst.so_line), .BUSY(busy));

    // First byte seen on the wire in each frame
    always @(negedge sef_if_inst.cs_n) nb = 0;
    always @(posedge sef_if_inst.sck) begin
        if (!sef_if_inst.cs_n && sef_if_inst.hold_n) begin
            sh = {sh[6:0], sef_if_inst.si};
            nb++;
            if (nb == 8) first_b = sh;
        end
    end

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic timeout(input string what);
        error_cnt++;
        $display("MISMATCH %s expected finish seen timeout", what);
        report_and_stop();
    endtask : timeout

    // One framed instruction; counts busy samples into hi
    task automatic xfer(input logic [7:0] op, input logic [15:0] a, input logic [7:0] n,
                        input logic [7:0] base);
        int cnt;
        int k;
        cnt = 0;
        k = 0;
        nrx = 0;
        hi = 0;
        start <= 1'b1;
        opcode <= op;
        addr <= a;
        addr_en <= (op != `SEF_OP_RDSTAT);
        nbytes <= n;
        wdata <= base;
        @(posedge clk);
        start <= 1'b0;
        while (done !== 1'b1) begin
            @(posedge clk);
            cnt++;
            if (cnt > 40000) timeout("frame");
            if (cnt == 1) check("active in frame", 1, active);
            if (busy === 1'b1) hi++;
            pause <= (cnt >= pause_at && cnt < pause_at + 60);
            if (wtake === 1'b1) begin
                k++;
                wdata <= base + 8'(k);
            end
            if (rvalid === 1'b1) begin
                rx[nrx] = rdata;
                nrx++;
            end
        end
        check("active after frame", 0, active);
        repeat (HALF + 3) begin
            @(posedge clk);
            if (busy === 1'b1) hi++;
        end
    endtask : xfer

    task automatic wait_idle;
        int cnt;
        cnt = 0;
        while (busy === 1'b1) begin
            @(posedge clk);
            cnt++;
            if (busy === 1'b1) hi++;
            if (cnt > 3 * TWC) timeout("busy");
        end
    endtask : wait_idle

    initial begin
        int i;
        int j;
        int rn;
        logic [15:0] b;
        logic [9:0] ad;
        arst_n <= 1'b0;
        start = 1'b0;
        opcode = 8'h00;
        addr = 16'h0000;
        addr_en = 1'b0;
        nbytes = 8'h00;
        wdata = 8'h00;
        pause = 1'b0;
        for (i = 0; i < 1024; i++) known[i] = 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 3; i++) begin
            xfer(`SEF_OP_WRITE, rows[i].a, rows[i].n, rows[i].base);
            wait_idle();
            check("busy cycles", TWC, hi);
            for (j = 0; j < rows[i].n; j++) begin
                ad = {rows[i].a[9:7], 7'(rows[i].a[6:0] + j)};
                mem[ad] = rows[i].base + 8'(j);
                known[ad] = 1'b1;
            end
            b = rows[i].a & 16'hff80;
            rn = (rows[i].a[6:0] + rows[i].n > 128) ? 128 : rows[i].a[6:0] + rows[i].n;
            xfer(`SEF_OP_READ, b, 8'(rn), 8'h00);
            check("row first byte", rows[i].x, rx[rows[i].a[6:0]]);
            for (j = 0; j < rn; j++) begin
                ad = 10'(b + j);
                if (known[ad]) check("read data", mem[ad], rx[j]);
            end
        end
        // Status and a refused read while programming
        xfer(`SEF_OP_WRITE, 16'h0200, 8'd2, 8'h77);
        xfer(`SEF_OP_RDSTAT, 16'h0000, 8'd2, 8'h00);
        check("status busy", 8'h01, rx[0]);
        check("status again", 8'h01, rx[1]);
        check("first wire byte", `SEF_OP_RDSTAT, first_b);
        xfer(`SEF_OP_READ, 16'h0200, 8'd1, 8'h00);
        check("read while busy", 8'hff, rx[0]);
        wait_idle();
        xfer(`SEF_OP_RDSTAT, 16'h0000, 8'd1, 8'h00);
        check("status ready", 8'h00, rx[0]);
        pause_at = 150;
        xfer(`SEF_OP_READ, 16'h0200, 8'd2, 8'h00);
        check("paused read 0", 8'h77, rx[0]);
        check("paused read 1", 8'h78, rx[1]);
        // Pause again while the front end drives data out
        pause_at = 270;
        xfer(`SEF_OP_READ, 16'h0200, 8'd2, 8'h00);
        pause_at = 100000;
        check("paused output 0", 8'h77, rx[0]);
        check("paused output 1", 8'h78, rx[1]);
        // Empty write and unknown code leave the array alone
        xfer(`SEF_OP_WRITE, 16'h0200, 8'd0, 8'h00);
        check("empty write busy", 0, hi);
        xfer(8'h55, 16'h0200, 8'd1, 8'h11);
        check("unknown code busy", 0, hi);
        check("unknown code output", 8'hff, rx[0]);
        xfer(`SEF_OP_READ, 16'h0200, 8'd1, 8'h00);
        check("array kept", 8'h77, rx[0]);
        // Reset in the middle of programming
        xfer(`SEF_OP_WRITE, 16'h0300, 8'd1, 8'h5a);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check("busy in reset", 0, busy);
        check("select in reset", 1, sef_if_inst.cs_n);
        check("active in reset", 0, active);
        arst_n <= 1'b1;
        @(posedge clk);
        xfer(`SEF_OP_RDSTAT, 16'h0000, 8'd1, 8'h00);
        check("status after reset", 8'h00, rx[0]);
        report_and_stop();
    end
endmodule : tb_spi_eeprom_serial_front_end
